// ==== logic/rtk_pkg.sv ====
// Package for the timekeeping and interval alarm block: map, fields, timing
package rtk_pkg;

	// SFR addresses
	localparam logic [7:0] ADDR_CONFIG = 8'ha1;
	localparam logic [7:0] ADDR_FRACTION = 8'ha2;
	localparam logic [7:0] ADDR_SEC = 8'ha3;
	localparam logic [7:0] ADDR_MIN = 8'ha4;
	localparam logic [7:0] ADDR_HOUR = 8'ha5;
	localparam logic [7:0] ADDR_INTERVAL = 8'ha6;
	localparam logic [7:0] ADDR_KEY = 8'hc1;
	localparam logic [7:0] ADDR_NOM_TRIM = 8'hf6;
	localparam logic [7:0] ADDR_THERM_TRIM = 8'hf7;
	localparam logic [7:0] ADDR_CAL_OPT = 8'hff;

	// Configuration bit positions
	localparam int BIT_MIDNIGHT = 7;
	localparam int BIT_HOUR24 = 6;
	localparam int BIT_TB_HI = 5;
	localparam int BIT_TB_LO = 4;
	localparam int BIT_SINGLE = 3;
	localparam int BIT_ALARM = 2;
	localparam int BIT_ITON = 1;
	localparam int BIT_KEEP_ON = 0;

	// Reset values
	localparam logic [7:0] CONFIG_RESET = 8'h01;
	localparam logic [7:0] REG_RESET = 8'h00;

	// Unlock key for the time counters
	localparam logic [7:0] TIME_KEY = 8'hea;

	// Wrap points
	localparam logic [7:0] FRACTION_MAX = 8'h7f;
	localparam logic [7:0] SEC_MAX = 8'h3b;
	localparam logic [7:0] MIN_MAX = 8'h3b;
	localparam logic [7:0] HOUR_MAX_24 = 8'h17;
	localparam logic [7:0] HOUR_MAX_256 = 8'hff;

	// Timing: crystal rate and ticks of 1/128 second
	localparam int XTAL_HZ = 32768;
	localparam int FRACTION_HZ = 128;
	localparam int XTAL_PER_FRACTION = XTAL_HZ / FRACTION_HZ;
	localparam logic [9:0] FRACTION_PERIOD = 10'(XTAL_PER_FRACTION);

	// Interval timebase selection
	typedef enum logic [1:0] {
		RTK_TB_FRACTION,
		RTK_TB_SECOND,
		RTK_TB_MINUTE,
		RTK_TB_HOUR
	} rtk_timebase_t;

	// One SFR access as seen from the core
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} rtk_sfr_req_t;

	// Configuration register contents
	typedef struct packed {
		logic midnight;
		logic hour24;
		rtk_timebase_t timebase;
		logic single_shot;
		logic alarm;
		logic iton;
		logic keep_on;
	} rtk_config_t;

endpackage

// ==== logic/rtk_timekeeper.sv ====
// Real-time clock: time counters, trim, interval alarm and SFR access
`timescale 1ns/1ps

module rtk_timekeeper
	import rtk_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic sys_rst,
	input wire logic xtal_clk,
	input wire rtk_pkg::rtk_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	output logic rtc_irq,
	output logic adc_strobe_en
);
	import rtk_pkg::*;

	// ==========================================================
	// Storage
	rtk_config_t config_q;
	logic [7:0] fraction;
	logic [7:0] seconds;
	logic [7:0] minutes;
	logic [7:0] hours;
	logic [7:0] interval_target;
	logic [7:0] interval_count;
	logic interval_done;
	logic [7:0] key_reg;
	logic unlocked;
	logic [7:0] nom_trim;
	logic [7:0] therm_trim;
	logic [7:0] cal_options;
	logic [1:0] xtal_sync;
	logic xtal_last;
	logic [9:0] prescale;

	// ==========================================================
	// Crystal edge detect
	// The crystal is sampled by the core clock; the first stage feeds only
	// the second, so a metastable sample never reaches the edge logic.
	wire xtal_rise = xtal_sync[1] & ~xtal_last;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			xtal_sync <= 2'b00;
			xtal_last <= 1'b0;
		end else begin
			xtal_sync <= {xtal_sync[0], xtal_clk};
			xtal_last <= xtal_sync[1];
		end
	end

	// ==========================================================
	// Trimmed 1/128 second prescaler
	// Both trims are signed; their sum shortens (positive) or stretches
	// (negative) the last fraction of each second, so the correction lands
	// once a second and never disturbs the fraction count itself.
	wire [8:0] trim_sum = {nom_trim[7], nom_trim} + {therm_trim[7], therm_trim};
	wire trim_slot = (fraction == FRACTION_MAX);
	wire [9:0] period_now = trim_slot ?
		10'(FRACTION_PERIOD - {trim_sum[8], trim_sum}) : FRACTION_PERIOD;
	wire prescale_end = xtal_rise && (prescale >= 10'(period_now - 10'd1));
	wire fraction_tick = prescale_end;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prescale <= 10'h000;
		end else if (prescale_end) begin
			prescale <= 10'h000;
		end else if (xtal_rise) begin
			prescale <= 10'(prescale + 10'd1);
		end
	end

	// ==========================================================
	// Time counter chain
	// Ticks do not depend on any core power state, so the chain keeps
	// counting whatever the core is doing.
	wire [7:0] hour_max = config_q.hour24 ? HOUR_MAX_24 : HOUR_MAX_256;
	wire fraction_wrap = fraction_tick && (fraction == FRACTION_MAX);
	wire sec_wrap = fraction_wrap && (seconds == SEC_MAX);
	wire min_wrap = sec_wrap && (minutes == MIN_MAX);
	wire hour_wrap = min_wrap && (hours == hour_max);

	wire [7:0] next_fraction = fraction_wrap ? 8'h00 :
		(fraction_tick ? 8'(fraction + 8'd1) : fraction);
	wire [7:0] next_seconds = sec_wrap ? 8'h00 :
		(fraction_wrap ? 8'(seconds + 8'd1) : seconds);
	wire [7:0] next_minutes = min_wrap ? 8'h00 :
		(sec_wrap ? 8'(minutes + 8'd1) : minutes);
	wire [7:0] next_hours = hour_wrap ? 8'h00 :
		(min_wrap ? 8'(hours + 8'd1) : hours);

	// ==========================================================
	// SFR decode
	wire wr = sfr_req.we;
	wire access = sfr_req.we | sfr_req.re;
	wire [7:0] wdata = sfr_req.wdata;
	wire wr_config = wr && (sfr_req.addr == ADDR_CONFIG);
	wire wr_interval = wr && (sfr_req.addr == ADDR_INTERVAL);
	wire wr_key = wr && (sfr_req.addr == ADDR_KEY);
	wire wr_nom = wr && (sfr_req.addr == ADDR_NOM_TRIM);
	wire wr_therm = wr && (sfr_req.addr == ADDR_THERM_TRIM);
	wire wr_cal = wr && (sfr_req.addr == ADDR_CAL_OPT);
	// Time counter writes pass only straight after the key.
	wire time_wr = wr && unlocked;
	wire wr_fraction = time_wr && (sfr_req.addr == ADDR_FRACTION);
	wire wr_sec = time_wr && (sfr_req.addr == ADDR_SEC);
	wire wr_min = time_wr && (sfr_req.addr == ADDR_MIN);
	wire wr_hour = time_wr && (sfr_req.addr == ADDR_HOUR);

	// ==========================================================
	// Interval timer
	wire tb_tick = (config_q.timebase == RTK_TB_FRACTION) ? fraction_tick :
		(config_q.timebase == RTK_TB_SECOND) ? fraction_wrap :
		(config_q.timebase == RTK_TB_MINUTE) ? sec_wrap : min_wrap;
	wire interval_run = config_q.iton && config_q.keep_on;
	wire [7:0] count_plus = 8'(interval_count + 8'd1);
	wire interval_hit = interval_run && !interval_done && tb_tick &&
		(count_plus == interval_target);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			interval_count <= 8'h00;
			interval_done <= 1'b0;
		end else if (!interval_run) begin
			interval_count <= 8'h00;
			interval_done <= 1'b0;
		end else if (interval_hit) begin
			interval_count <= 8'h00;
			interval_done <= config_q.single_shot;
		end else if (tb_tick && !interval_done) begin
			interval_count <= count_plus;
		end
	end

	// ==========================================================
	// Flags
	// Software clears a flag by writing zero to its bit; writing one leaves
	// it alone. A new event in the same cycle beats the clear.
	wire next_midnight = hour_wrap ||
		(config_q.midnight && !(wr_config && !wdata[BIT_MIDNIGHT]));
	wire next_alarm = interval_hit ||
		(config_q.alarm && !(wr_config && !wdata[BIT_ALARM]));

	// ==========================================================
	// Configuration register
	// The 24-hour bit lives on power-on reset only; the rest of the control
	// bits also return to default on a watchdog or pin reset.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			config_q <= rtk_config_t'(CONFIG_RESET);
		end else begin
			config_q.midnight <= next_midnight;
			config_q.alarm <= next_alarm;
			if (wr_config) begin
				config_q.hour24 <= wdata[BIT_HOUR24];
			end
			if (sys_rst) begin
				config_q.timebase <= RTK_TB_FRACTION;
				config_q.single_shot <= CONFIG_RESET[BIT_SINGLE];
				config_q.iton <= CONFIG_RESET[BIT_ITON];
				config_q.keep_on <= CONFIG_RESET[BIT_KEEP_ON];
			end else if (wr_config) begin
				config_q.timebase <=
					rtk_timebase_t'(wdata[BIT_TB_HI:BIT_TB_LO]);
				config_q.single_shot <= wdata[BIT_SINGLE];
				config_q.iton <= wdata[BIT_ITON];
				config_q.keep_on <= wdata[BIT_KEEP_ON];
			end
		end
	end

	// ==========================================================
	// Time counters
	// Only nrst clears them; sys_rst is deliberately not seen here.
	// A counter write in the same cycle as a tick wins over the tick.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fraction <= REG_RESET;
			seconds <= REG_RESET;
			minutes <= REG_RESET;
			hours <= REG_RESET;
		end else begin
			fraction <= wr_fraction ? wdata : next_fraction;
			seconds <= wr_sec ? wdata : next_seconds;
			minutes <= wr_min ? wdata : next_minutes;
			hours <= wr_hour ? wdata : next_hours;
		end
	end

	// ==========================================================
	// Key register and one-shot unlock
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			key_reg <= REG_RESET;
			unlocked <= 1'b0;
		end else if (sys_rst) begin
			key_reg <= REG_RESET;
			unlocked <= 1'b0;
		end else begin
			if (wr_key) begin
				key_reg <= wdata;
			end
			if (access) begin
				unlocked <= wr_key && (wdata == TIME_KEY);
			end
		end
	end

	// ==========================================================
	// Trim, interval target and calibration options
	// The nominal trim goes back to zero on any reset; the others clear on nrst only and keep through sys_rst.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			nom_trim <= REG_RESET;
			therm_trim <= REG_RESET;
			interval_target <= REG_RESET;
			cal_options <= REG_RESET;
		end else begin
			if (sys_rst) begin
				nom_trim <= REG_RESET;
			end else if (wr_nom) begin
				nom_trim <= wdata;
			end
			if (wr_therm) begin
				therm_trim <= wdata;
			end
			if (wr_interval) begin
				interval_target <= wdata;
			end
			if (wr_cal) begin
				cal_options <= wdata;
			end
		end
	end

	// ==========================================================
	// Read path
	// Reads come straight from the counters, which are clocked in the core domain, so a counter
	// never changes half way through a read.
	logic [7:0] read_mux;
	logic read_map;

	always_comb begin
		read_mux = 8'h00;
		read_map = 1'b1;
		unique case (sfr_req.addr)
			ADDR_CONFIG: read_mux = config_q;
			ADDR_FRACTION: read_mux = fraction;
			ADDR_SEC: read_mux = seconds;
			ADDR_MIN: read_mux = minutes;
			ADDR_HOUR: read_mux = hours;
			ADDR_INTERVAL: read_mux = interval_target;
			ADDR_KEY: read_mux = key_reg;
			ADDR_NOM_TRIM: read_mux = nom_trim;
			ADDR_THERM_TRIM: read_mux = therm_trim;
			ADDR_CAL_OPT: read_mux = cal_options;
			default: read_map = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sfr_rdata <= 8'h00;
			sfr_hit <= 1'b0;
		end else begin
			sfr_rdata <= (sfr_req.re && read_map) ? read_mux : 8'h00;
			sfr_hit <= access && read_map;
		end
	end

	// ==========================================================
	// Interrupt and strobe enable
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rtc_irq <= 1'b0;
			adc_strobe_en <= CONFIG_RESET[BIT_KEEP_ON];
		end else begin
			rtc_irq <= next_midnight || next_alarm;
			adc_strobe_en <= sys_rst ? CONFIG_RESET[BIT_KEEP_ON] :
				(wr_config ? wdata[BIT_KEEP_ON] : config_q.keep_on);
		end
	end

endmodule

// ==== sim/rtk_timekeeper_asserts.sv ====
// Checker on the timekeeper ports
`timescale 1ns/1ps
module rtk_timekeeper_asserts (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic sys_rst,
	input wire logic xtal_clk,
	input wire rtk_pkg::rtk_sfr_req_t sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	input wire logic rtc_irq,
	input wire logic adc_strobe_en
);
	import rtk_pkg::*;
	// =====
	// Decode
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire logic [7:0] a = sfr_req.addr;
	wire logic acc = sfr_req.we | sfr_req.re;
	wire logic cfg_wr = sfr_req.we && a == ADDR_CONFIG;
	wire logic cfg_rd = sfr_req.re && a == ADDR_CONFIG;
	wire logic mapped = (a >= 8'ha1 && a <= 8'ha6) || a == 8'hc1
		|| a == 8'hf6 || a == 8'hf7 || a == 8'hff;
	AST_HIT_MAP: assert property (acc && mapped |=> sfr_hit)
		else $error("mapped access without hit");
	AST_UNMAPPED: assert property (acc && !mapped |=>
		!sfr_hit && sfr_rdata == 8'h00) else $error("unmapped answered");
	AST_IDLE: assert property (!acc |=> !sfr_hit && sfr_rdata == 8'h00)
		else $error("answer without access");
	AST_CFG_RW: assert property (cfg_wr ##2 cfg_rd |=>
		sfr_rdata[6:3] == $past(sfr_req.wdata[6:3], 3)
		&& sfr_rdata[1:0] == $past(sfr_req.wdata[1:0], 3))
		else $error("config readback differs");
	AST_KEY_READ: assert property (sfr_req.we && a == ADDR_KEY ##2
		sfr_req.re && a == ADDR_KEY |=> sfr_rdata == $past(sfr_req.wdata, 3))
		else $error("key readback differs");
	AST_IRQ_FLAGS: assert property ($past(cfg_rd) |->
		$past(rtc_irq) == (sfr_rdata[7] | sfr_rdata[2]))
		else $error("irq level differs from flags");
	AST_IRQ_FALL: assert property ($fell(rtc_irq) |->
		$past(cfg_wr) || $past(cfg_wr, 2)) else $error("irq fell alone");
	AST_STROBE_SYSRST: assert property (sys_rst |-> ##2 adc_strobe_en)
		else $error("strobe enable low after sys reset");
	C_IRQ: cover property ($rose(rtc_irq));
	C_CFG_IRQ: cover property ($past(cfg_rd) && sfr_rdata[7]);
	C_SYSRST: cover property (sys_rst);
endmodule
bind rtk_timekeeper rtk_timekeeper_asserts i_rtk_timekeeper_asserts (
	.mclk(mclk), .nrst(nrst), .sys_rst(sys_rst), .xtal_clk(xtal_clk),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
	.rtc_irq(rtc_irq), .adc_strobe_en(adc_strobe_en));

// ==== sim/rtk_core_model.sv ====
// Core model issuing SFR accesses one at a time
`timescale 1ns/1ps
module rtk_core_model (
	input wire logic mclk,
	output rtk_pkg::rtk_sfr_req_t sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit
);
	import rtk_pkg::*;
	// =====
	// Accesses
	initial sfr_req = '{8'h00, 8'h00, 1'b0, 1'b0};
	// Released bus shows inverted values so stale data cannot pass
	task automatic acc(input logic [7:0] a, input logic [7:0] d,
		input logic w, output logic [7:0] q);
		@(negedge mclk);
		sfr_req = '{a, d, w, ~w};
		@(negedge mclk);
		q = sfr_rdata;
		sfr_req = '{~a, ~d, 1'b0, 1'b0};
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(a, d, 1'b1, q);
	endtask
	task automatic wr_time(input logic [7:0] a, input logic [7:0] d);
		wr(ADDR_KEY, TIME_KEY);
		wr(a, d);
	endtask
endmodule

// ==== sim/tb_top.sv ====
// Testbench for the timekeeping and interval alarm block
`timescale 1ns/1ps
module tb_top;
	import rtk_pkg::*;
	// =====
	// Harness
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic sys_rst = 1'b0;
	logic xtal_clk = 1'b0;
	rtk_sfr_req_t sfr_req;
	logic [7:0] sfr_rdata;
	logic sfr_hit;
	logic rtc_irq;
	logic adc_strobe_en;
	int failures = 0;
	int check_count = 0;
	always #4 mclk = ~mclk;
	// Crystal sped up so a 1/128 s tick takes about 2624 cycles
	always #41 xtal_clk = ~xtal_clk;
	rtk_timekeeper i_rtk_timekeeper (.mclk(mclk), .nrst(nrst),
		.sys_rst(sys_rst), .xtal_clk(xtal_clk), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .rtc_irq(rtc_irq),
		.adc_strobe_en(adc_strobe_en));
	rtk_core_model i_rtk_core_model (.mclk(mclk), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit));
	// =====
	// Helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		i_rtk_core_model.acc(a, 8'h00, 1'b0, q);
		chk(q, exp);
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		i_rtk_core_model.wr(a, d);
	endtask
	task automatic set_time(input logic [7:0] h, m, s, f);
		i_rtk_core_model.wr_time(ADDR_HOUR, h);
		i_rtk_core_model.wr_time(ADDR_MIN, m);
		i_rtk_core_model.wr_time(ADDR_SEC, s);
		i_rtk_core_model.wr_time(ADDR_FRACTION, f);
	endtask
	task automatic wait_irq(input int n);
		for (int i = 0; i < n && rtc_irq !== 1'b1; i++)
			@(negedge mclk);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// =====
	// Scenarios
	task automatic t_reset;
		logic [7:0] regs [9] = '{8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6,
			8'hc1, 8'hf6, 8'hf7, 8'hff};
		rd(ADDR_CONFIG, CONFIG_RESET);
		foreach (regs[i])
			rd(regs[i], REG_RESET);
		rd(8'h00, 8'h00);
	endtask
	task automatic t_lock;
		w(ADDR_SEC, 8'h10);
		rd(ADDR_SEC, 8'h00);
		w(ADDR_KEY, TIME_KEY);
		rd(ADDR_KEY, TIME_KEY);
		w(ADDR_SEC, 8'h10);
		rd(ADDR_SEC, 8'h00);
		i_rtk_core_model.wr_time(ADDR_SEC, 8'h10);
		rd(ADDR_SEC, 8'h10);
	endtask
	task automatic t_wrap;
		logic [7:0] cfg [3] = '{8'h41, 8'h01, 8'h01};
		logic [7:0] hr [3] = '{8'h17, 8'hff, 8'h17};
		for (int i = 0; i < 3; i++) begin
			w(ADDR_CONFIG, cfg[i]);
			set_time(hr[i], 8'h3b, 8'h3b, 8'h7f);
			wait_irq(3000);
			chk(8'(rtc_irq), 8'(i < 2));
			rd(ADDR_CONFIG, cfg[i] | (i < 2 ? 8'h80 : 8'h00));
			rd(ADDR_HOUR, i < 2 ? 8'h00 : 8'h18);
			rd(ADDR_MIN, 8'h00);
			rd(ADDR_SEC, 8'h00);
			if (i < 2)
				rd(ADDR_FRACTION, 8'h00);
		end
		w(ADDR_CONFIG, 8'h41);
		rd(ADDR_CONFIG, 8'h41);
	endtask
	task automatic t_sysrst;
		w(ADDR_CONFIG, 8'h7b);
		w(ADDR_NOM_TRIM, 8'h05);
		w(ADDR_THERM_TRIM, 8'h07);
		i_rtk_core_model.wr_time(ADDR_MIN, 8'h2a);
		@(negedge mclk) sys_rst = 1'b1;
		@(negedge mclk) sys_rst = 1'b0;
		rd(ADDR_CONFIG, 8'h41);
		rd(ADDR_MIN, 8'h2a);
		rd(ADDR_NOM_TRIM, 8'h00);
		rd(ADDR_THERM_TRIM, 8'h07);
		// Thermal trim survives the reset; zero it so later timing is nominal
		w(ADDR_THERM_TRIM, 8'h00);
		rd(ADDR_THERM_TRIM, 8'h00);
	endtask
	task automatic t_interval;
		w(ADDR_INTERVAL, 8'h02);
		w(ADDR_CONFIG, 8'h03);
		for (int i = 0; i < 2; i++) begin
			wait_irq(6000);
			rd(ADDR_CONFIG, 8'h07);
			w(ADDR_CONFIG, 8'h03);
			chk(8'(rtc_irq), 8'h00);
		end
		w(ADDR_CONFIG, 8'h0b);
		wait_irq(6000);
		chk(8'(rtc_irq), 8'h01);
		w(ADDR_CONFIG, 8'h0b);
		wait_irq(6000);
		chk(8'(rtc_irq), 8'h00);
		w(ADDR_CONFIG, 8'h02);
		wait_irq(6000);
		chk(8'(rtc_irq), 8'h00);
		chk(8'(adc_strobe_en), 8'h00);
		w(ADDR_CONFIG, 8'h01);
		wait_irq(6000);
		chk(8'(rtc_irq), 8'h00);
		w(ADDR_INTERVAL, 8'h01);
		for (int t = 1; t < 4; t++) begin
			w(ADDR_CONFIG, 8'h01);
			w(ADDR_CONFIG, {2'b00, 2'(t), 4'hb});
			set_time(8'h00, t > 2 ? 8'h3b : 8'h00, t > 1 ? 8'h3b : 8'h00, 8'h7f);
			wait_irq(3000);
			chk(8'(rtc_irq), 8'h01);
		end
	endtask
	initial begin
		repeat (16) @(negedge mclk);
		nrst = 1'b1;
		t_reset();
		t_lock();
		t_wrap();
		t_sysrst();
		t_interval();
		test_done();
	end
	initial begin
		#720us;
		failures++;
		test_done();
	end
endmodule
